// [rtl/frak_fault_ack.sv]
// Fault latches, acknowledge pulse decoder and indicators
`timescale 1ns/10ps
`default_nettype none
`include "frak_defs.svh"
module frak_fault_ack
  import frak_pkg::*;
#(
  parameter int TICK_CYC = `FRAK_TICK_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sync_clear,
  input wire logic pulse_in,
  input wire logic overpressure,
  input wire logic supply_low,
  input wire logic diag_fatal,
  input wire logic cartridge_empty,
  input wire logic self_check_ok,
  output logic status_out,
  output logic red_led,
  output logic [2:0] fault_code,
  output logic ctrl_pulse_accept,
  output logic ack_done
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 5'h00;
      sync_reg <= 5'h00;
    end else begin
      meta_reg <= {pulse_in, overpressure, supply_low, diag_fatal, cartridge_empty};
      sync_reg <= meta_reg;
    end
  end
  wire logic pulse_s = sync_reg[4];
  wire logic over_s = sync_reg[3];
  wire logic uv_s = sync_reg[2];
  wire logic fatal_s = sync_reg[1];
  wire logic empty_s = sync_reg[0];
  // ------------------------------------------------------------
  // Prescaled tick
  // ------------------------------------------------------------
  // Slow tick keeps the pulse counters narrow
  logic [31:0] pre_reg;
  logic tick_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (pre_reg == 32'(TICK_CYC - 1));
      pre_reg <= (pre_reg == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
    end
  end
  // ------------------------------------------------------------
  // Pulse length measurement
  // ------------------------------------------------------------
  frak_state_t state_reg, state_next;
  logic [15:0] len_reg;
  logic pulse_d_reg;
  wire logic pulse_fall = pulse_d_reg && !pulse_s;
  wire logic len_ok = (len_reg >= 16'(`FRAK_ACK_MIN_TICKS)) &&
                      (len_reg <= 16'(`FRAK_ACK_MAX_TICKS));
  frak_faults_t flt_reg;
  wire logic any_fault = |flt_reg;
  wire logic ackable = (flt_reg.overload_fault || flt_reg.undervoltage_fault)
                       && !flt_reg.fatal_fault && !flt_reg.empty_cartridge_fault;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FRAK_IDLE: if (pulse_s) state_next = FRAK_HIGH;
      FRAK_HIGH: if (pulse_fall) state_next = (len_ok && ackable) ? FRAK_CHECK : FRAK_IDLE;
      FRAK_CHECK: state_next = FRAK_IDLE;
      default: state_next = FRAK_IDLE;
    endcase
  end
  wire logic ack_pass = (state_reg == FRAK_CHECK) && self_check_ok;
  wire logic ack_fail = (state_reg == FRAK_CHECK) && !self_check_ok;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= FRAK_IDLE;
      len_reg <= 16'h0000;
      pulse_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pulse_d_reg <= pulse_s;
      if (!pulse_s) len_reg <= 16'h0000;
      else if (tick_reg && len_reg != 16'hFFFF) len_reg <= len_reg + 16'h0001;
    end
  end
  // ------------------------------------------------------------
  // Fault latches
  // ------------------------------------------------------------
  // Set terms win over the acknowledge clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flt_reg <= '0;
    end else if (sync_clear) begin
      flt_reg <= '0;
    end else begin
      flt_reg.empty_cartridge_fault <= empty_s;
      if (over_s) flt_reg.overload_fault <= 1'b1;
      else if (ack_pass) flt_reg.overload_fault <= 1'b0;
      if (uv_s) flt_reg.undervoltage_fault <= 1'b1;
      else if (ack_pass) flt_reg.undervoltage_fault <= 1'b0;
      if (fatal_s || ack_fail) flt_reg.fatal_fault <= 1'b1;
    end
  end
  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic [15:0] blink_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      blink_reg <= 16'h0000;
    end else if (!flt_reg.empty_cartridge_fault) begin
      blink_reg <= 16'h0000;
    end else if (tick_reg) begin
      blink_reg <= (blink_reg == 16'(`FRAK_BLINK_TICKS - 1)) ? 16'h0000 : blink_reg + 16'h0001;
    end
  end
  wire logic [2:0] code_w = flt_reg.fatal_fault ? `FRAK_CODE_FATAL :
                            flt_reg.overload_fault ? `FRAK_CODE_OVERLOAD :
                            flt_reg.undervoltage_fault ? `FRAK_CODE_UNDERVOLT :
                            flt_reg.empty_cartridge_fault ? `FRAK_CODE_EMPTY : `FRAK_CODE_NONE;
  wire logic red_w = (flt_reg.fatal_fault || flt_reg.overload_fault || flt_reg.undervoltage_fault)
                     || (flt_reg.empty_cartridge_fault &&
                         blink_reg < 16'(`FRAK_BLINK_ON_TICKS));
  // Empty fault square wave on the status line is out of scope; held high here
  wire logic low_w = flt_reg.overload_fault || flt_reg.undervoltage_fault || flt_reg.fatal_fault;
  // Ordinary pulses pass only with no fault pending
  wire logic accept_w = pulse_fall && !any_fault && !(len_ok && ackable);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_out <= 1'b1;
      red_led <= 1'b0;
      fault_code <= `FRAK_CODE_NONE;
      ctrl_pulse_accept <= 1'b0;
      ack_done <= 1'b0;
    end else begin
      status_out <= !low_w;
      red_led <= red_w;
      fault_code <= code_w;
      ctrl_pulse_accept <= accept_w;
      ack_done <= ack_pass;
    end
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_OVER_LOW: assert property (@(posedge mclk) disable iff (!resetn)
    flt_reg.overload_fault |=> !status_out) else $error("status high under overload");
  AST_UV_LOW: assert property (@(posedge mclk) disable iff (!resetn)
    flt_reg.undervoltage_fault |=> !status_out) else $error("status high under undervolt");
  AST_OVER_CLR: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(flt_reg.overload_fault) |-> $past(ack_pass) || $past(sync_clear))
    else $error("overload cleared without acknowledge");
  AST_UV_CLR: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(flt_reg.undervoltage_fault) |-> $past(ack_pass) || $past(sync_clear))
    else $error("undervolt cleared without acknowledge");
  AST_FATAL_STAYS: assert property (@(posedge mclk) disable iff (!resetn)
    flt_reg.fatal_fault && !sync_clear |=> flt_reg.fatal_fault) else $error("fatal cleared");
  AST_FATAL_LOW: assert property (@(posedge mclk) disable iff (!resetn)
    flt_reg.fatal_fault |=> !status_out && fault_code == `FRAK_CODE_FATAL)
    else $error("fatal not shown");
  AST_NO_ACCEPT: assert property (@(posedge mclk) disable iff (!resetn)
    any_fault |=> !ctrl_pulse_accept) else $error("pulse accepted under fault");
  AST_LOW_ACCEPT: assert property (@(posedge mclk) disable iff (!resetn)
    !status_out |-> !ctrl_pulse_accept) else $error("pulse accepted while low");
  AST_FALL_ONLY: assert property (@(posedge mclk) disable iff (!resetn)
    !pulse_fall |=> !ctrl_pulse_accept) else $error("accept without a pulse end");
  // Acknowledge walk: valid fall, one check cycle, then clear or fatal
  sequence s_ack_fall;
    state_reg == FRAK_HIGH && pulse_fall && len_ok && ackable;
  endsequence
  sequence s_check_pass;
    state_reg == FRAK_CHECK && self_check_ok && !flt_reg.fatal_fault &&
    !over_s && !uv_s && !fatal_s && !sync_clear;
  endsequence
  sequence s_check_fail;
    state_reg == FRAK_CHECK && !self_check_ok && !sync_clear;
  endsequence
  AST_ACK_STEP: assert property (@(posedge mclk) disable iff (!resetn)
    s_ack_fall |=> state_reg == FRAK_CHECK) else $error("valid acknowledge not checked");
  AST_ACK_REFUSED: assert property (@(posedge mclk) disable iff (!resetn)
    state_reg == FRAK_HIGH && pulse_fall && !(len_ok && ackable) |=> state_reg == FRAK_IDLE)
    else $error("refused pulse reached check");
  AST_ACK_PASS: assert property (@(posedge mclk) disable iff (!resetn)
    s_check_pass |=> (ack_done && !flt_reg.overload_fault && !flt_reg.undervoltage_fault)
    ##1 status_out) else $error("passed check left status low");
  AST_CHECK_FAIL: assert property (@(posedge mclk) disable iff (!resetn)
    s_check_fail |=> flt_reg.fatal_fault ##1 !status_out) else $error("failed check not fatal");
  AST_RED: assert property (@(posedge mclk) disable iff (!resetn)
    low_w |=> red_led && fault_code != `FRAK_CODE_NONE) else $error("red off under fault");
  // Empty alone keeps status high; red only in the short slot
  AST_EMPTY_SHOW: assert property (@(posedge mclk) disable iff (!resetn)
    flt_reg.empty_cartridge_fault && !low_w |=> status_out && fault_code == `FRAK_CODE_EMPTY)
    else $error("empty fault not shown");
  AST_BLINK_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    flt_reg.empty_cartridge_fault && !low_w && blink_reg >= 16'(`FRAK_BLINK_ON_TICKS)
    |=> !red_led) else $error("red on outside blink slot");
  AST_NO_FAULT: assert property (@(posedge mclk) disable iff (!resetn)
    !any_fault |=> status_out && !red_led && fault_code == `FRAK_CODE_NONE)
    else $error("fault shown with none pending");
  AST_CLEAR: assert property (@(posedge mclk) disable iff (!resetn)
    sync_clear |=> flt_reg == '0) else $error("clear missed");
endmodule : frak_fault_ack
`default_nettype wire

// [rtl/frak_defs.svh]
// Constants for the fault report and acknowledge block
`ifndef FRAK_DEFS_SVH
`define FRAK_DEFS_SVH
// Clock rate and prescaled tick
`define FRAK_CLK_HZ 25000000
`define FRAK_TICK_HZ 100
`define FRAK_TICK_CYC (`FRAK_CLK_HZ / `FRAK_TICK_HZ)
// Acknowledge window in milliseconds, printed as 13.9 .. 14.1 s
`define FRAK_ACK_MIN_MS 13900
`define FRAK_ACK_MAX_MS 14100
`define FRAK_ACK_MIN_TICKS ((`FRAK_ACK_MIN_MS * `FRAK_TICK_HZ + 999) / 1000)
`define FRAK_ACK_MAX_TICKS ((`FRAK_ACK_MAX_MS * `FRAK_TICK_HZ) / 1000)
// Red indicator period and pulse length for the empty fault
`define FRAK_BLINK_MS 5000
`define FRAK_BLINK_TICKS ((`FRAK_BLINK_MS * `FRAK_TICK_HZ) / 1000)
`define FRAK_BLINK_ON_TICKS 10
// Fault codes shown on the display
`define FRAK_CODE_NONE 3'h0
`define FRAK_CODE_EMPTY 3'h1
`define FRAK_CODE_OVERLOAD 3'h2
`define FRAK_CODE_UNDERVOLT 3'h3
`define FRAK_CODE_FATAL 3'h4
`endif

// [rtl/frak_pkg.sv]
// Types for the fault report and acknowledge block
package frak_pkg;
  typedef enum logic [2:0] {
    FRAK_IDLE = 3'b001,
    FRAK_HIGH = 3'b010,
    FRAK_CHECK = 3'b100
  } frak_state_t;
  typedef struct packed {
    logic empty_cartridge_fault;
    logic overload_fault;
    logic undervoltage_fault;
    logic fatal_fault;
  } frak_faults_t;
endpackage : frak_pkg

// [verif/frak_plc_model.sv]
// Controller model that drives the control pulse line
`timescale 1ns/10ps
`default_nettype none
module frak_plc_model #(
  parameter int TICK_CYC = 10
) (
  input wire logic mclk,
  input wire logic status_out,
  output logic pulse_in
);
  // Line is actively driven low between pulses
  initial pulse_in = 1'b0;
  task automatic send(input int ticks);
    @(negedge mclk);
    pulse_in = 1'b1;
    repeat (ticks * TICK_CYC) @(negedge mclk);
    pulse_in = 1'b0;
  endtask : send
  // Acknowledge only once the cause is gone and a fault shows
  task automatic acknowledge(input logic cause_gone);
    if (cause_gone && status_out === 1'b0) send(1400);
  endtask : acknowledge
endmodule : frak_plc_model
`default_nettype wire

// [verif/frak_fault_ack_tb_top.sv]
// Testbench for the fault report and acknowledge block
`timescale 1ns/10ps
`default_nettype none
module frak_fault_ack_tb_top;
  import frak_pkg::*;
  // Short tick keeps a 14 s pulse at 14000 cycles
  localparam int TICK = 10;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic sync_clear, overpressure, supply_low;
  logic diag_fatal, cartridge_empty, self_check_ok;
  logic pulse_in, status_out, red_led, ctrl_pulse_accept, ack_done;
  logic [2:0] fault_code;
  logic [15:0] acc_cnt = 16'h0000, ack_cnt = 16'h0000, red_cnt = 16'h0000, red_mark;
  int bad_count = 0;
  int compares = 0;
  frak_fault_ack #(.TICK_CYC(TICK)) frak_fault_ack_inst (.mclk(mclk), .resetn(resetn),
    .sync_clear(sync_clear), .pulse_in(pulse_in), .overpressure(overpressure),
    .supply_low(supply_low), .diag_fatal(diag_fatal), .cartridge_empty(cartridge_empty),
    .self_check_ok(self_check_ok), .status_out(status_out), .red_led(red_led),
    .fault_code(fault_code), .ctrl_pulse_accept(ctrl_pulse_accept), .ack_done(ack_done));
  frak_plc_model #(.TICK_CYC(TICK)) frak_plc_model_inst (.mclk(mclk),
    .status_out(status_out), .pulse_in(pulse_in));
  initial begin
    forever #20 mclk = ~mclk;
  end
  // One-cycle outputs are counted so no pulse is missed
  always @(posedge mclk) begin
    acc_cnt <= acc_cnt + 16'(ctrl_pulse_accept === 1'b1);
    ack_cnt <= ack_cnt + 16'(ack_done === 1'b1);
    red_cnt <= red_cnt + 16'(red_led === 1'b1);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic state_is(input logic s, input logic r, input logic [2:0] c);
    check(16'({status_out, red_led, fault_code}), 16'({s, r, c}));
  endtask : state_is
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_n
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    sync_clear = 1'b0;
    overpressure = 1'b0;
    supply_low = 1'b0;
    diag_fatal = 1'b0;
    cartridge_empty = 1'b0;
    self_check_ok = 1'b1;
    wait_n(20);
    state_is(1'b1, 1'b0, 3'h0);
    resetn = 1'b1;
    frak_plc_model_inst.send(100);
    wait_n(10);
    check(acc_cnt, 16'h0001);
    $display("test plain pulse done");
    overpressure = 1'b1;
    wait_n(10);
    state_is(1'b0, 1'b1, 3'h2);
    frak_plc_model_inst.send(100);
    overpressure = 1'b0;
    wait_n(10);
    check(acc_cnt, 16'h0001);
    state_is(1'b0, 1'b1, 3'h2);
    frak_plc_model_inst.acknowledge(1'b1);
    wait_n(10);
    check(ack_cnt, 16'h0001);
    state_is(1'b1, 1'b0, 3'h0);
    $display("test overload done");
    supply_low = 1'b1;
    wait_n(10);
    state_is(1'b0, 1'b1, 3'h3);
    supply_low = 1'b0;
    self_check_ok = 1'b0;
    frak_plc_model_inst.acknowledge(1'b1);
    wait_n(10);
    state_is(1'b0, 1'b1, 3'h4);
    self_check_ok = 1'b1;
    frak_plc_model_inst.acknowledge(1'b1);
    wait_n(10);
    check(ack_cnt, 16'h0001);
    state_is(1'b0, 1'b1, 3'h4);
    sync_clear = 1'b1;
    wait_n(2);
    sync_clear = 1'b0;
    wait_n(4);
    state_is(1'b1, 1'b0, 3'h0);
    diag_fatal = 1'b1;
    wait_n(6);
    diag_fatal = 1'b0;
    wait_n(10);
    state_is(1'b0, 1'b1, 3'h4);
    sync_clear = 1'b1;
    wait_n(2);
    sync_clear = 1'b0;
    $display("test undervoltage and fatal done");
    cartridge_empty = 1'b1;
    frak_plc_model_inst.send(100);
    wait_n(10);
    check(16'({status_out, fault_code}), 16'h0009);
    check(acc_cnt, 16'h0001);
    red_mark = red_cnt;
    wait_n(500 * TICK);
    check(red_cnt - red_mark, 16'(10 * TICK));
    $display("test empty done");
    tally_and_finish();
  end
  // Run needs about 50000 cycles; this cuts a hang short
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    tally_and_finish();
  end
endmodule : frak_fault_ack_tb_top
`default_nettype wire
